//--- dv/dcc_partner.sv
`timescale 1ns/1ps
// ======
// Timer (counts while run is high) and converter stand-in
module dcc_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic adc_start,
    output logic [15:0] timer,
    output int trig_n
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= 16'h0000;
            trig_n <= 0;
        end else begin
            if (run) timer <= timer + 16'h0001;
            if (adc_start) trig_n <= trig_n + 1;
        end
    end
endmodule

//--- dv/dcc_top_asserts.sv
`timescale 1ns/1ps
// ======
// Port checks
module dcc_top_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] sixteen_bit_timer,
    input wire logic channel_one_compare_pin,
    input wire logic channel_two_compare_pin,
    input wire logic channel_one_compare_oe,
    input wire logic channel_two_compare_oe,
    input wire logic adc_start
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire rd = psel && penable && !pwrite;
    a_ready_high: assert property (pready)
        else $error("ready low");
    a_err_unmapped: assert property (psel && penable && paddr > 12'h018
        |-> pslverr) else $error("no error on unmapped");
    a_err_readzero: assert property (rd && pslverr
        |-> prdata == 32'h0) else $error("error read not zero");
    a_mode_upper: assert property (rd && paddr == 12'h000
        |-> prdata[31:8] == 24'h0) else $error("mode upper bits set");
    a_timer_read: assert property (rd && paddr == 12'h014
        |-> prdata == {16'h0, $past(sixteen_bit_timer)})
        else $error("timer read wrong");
    a_trig_pulse: assert property (adc_start |=> !adc_start)
        else $error("trigger longer than one cycle");
    a_pin_hold1: assert property ((!channel_one_compare_oe)[*3]
        |-> $stable(channel_one_compare_pin)) else $error("pin one moved");
    a_pin_hold2: assert property ((!channel_two_compare_oe)[*3]
        |-> $stable(channel_two_compare_pin)) else $error("pin two moved");
endmodule

bind dcc_top dcc_top_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .sixteen_bit_timer,
    .channel_one_compare_pin, .channel_two_compare_pin,
    .channel_one_compare_oe, .channel_two_compare_oe, .adc_start);

//--- dv/dcc_top_tb.sv
`timescale 1ns/1ps
`include "dcc_regs.svh"
// ======
// Bench
module dcc_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, cap = 0, run = 1, adc_en = 1, err;
    logic adc_start, irq;
    logic [1:0] pin, oe;
    logic [15:0] timer;
    int trig_n, n_mismatch = 0, check_count = 0;
    always #2.5 pclk = ~pclk;
    dcc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sixteen_bit_timer(timer),
        .capture_input_pin(cap), .adc_enabled(adc_en),
        .channel_one_compare_pin(pin[0]), .channel_two_compare_pin(pin[1]),
        .channel_one_compare_oe(oe[0]), .channel_two_compare_oe(oe[1]),
        .adc_start, .irq);
    dcc_partner tmr (.pclk, .presetn, .run, .adc_start, .timer, .trig_n);
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (irq !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            cap <= 1;
            repeat (4) @(posedge pclk);
            cap <= 0;
            repeat (4) @(posedge pclk);
        end
    endtask
    task automatic t_regs;
        xfer(0, `DCC_ADDR_MODE, 32'h0);
        check(rd, 32'h0);
        xfer(1, `DCC_ADDR_MODE, 32'hffff_ffa5);
        xfer(0, `DCC_ADDR_MODE, 32'h0);
        check(rd, 32'ha5);
        check(err, 1'b0);
        xfer(0, 12'h01c, 32'h0);
        check(rd, 32'h0);
        check(err, 1'b1);
        run <= 0;
        @(posedge pclk);
        xfer(0, `DCC_ADDR_TIMER, 32'h0);
        check(rd, {16'h0, timer});
        run <= 1;
        $display("test regs done");
    endtask
    task automatic t_cmp;
        logic [3:0] m;
        int t0;
        xfer(1, `DCC_ADDR_MASK, 32'h3);
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 8; i < 17; i++) begin
                m = (i > 15) ? 4'hf : 4'(i);
                adc_en <= (i < 16);
                xfer(1, `DCC_ADDR_MODE, 32'h0);
                xfer(1, `DCC_ADDR_STATUS, 32'h3);
                check(pin[ch], 1'b0);
                t0 = trig_n;
                xfer(1, `DCC_ADDR_VAL1 + 12'(4 * ch),
                    {16'h0, timer + 16'h0028});
                check(irq, 1'b0);
                xfer(1, `DCC_ADDR_MODE, 32'(m) << (4 * ch));
                repeat (3) @(posedge pclk);
                check(pin[ch], m == 4'h9);
                check(oe[ch], m < 4'hb);
                if (m == 4'hb) repeat (60) @(posedge pclk);
                else wait_irq(60);
                @(posedge pclk);
                check(irq, m != 4'hb);
                check(pin[ch], m == 4'h8 || m == 4'ha);
                check(trig_n - t0, m == 4'hf && i < 16);
                xfer(0, `DCC_ADDR_STATUS, 32'h0);
                check(rd, (m == 4'hb) ? 0 : 1 << ch);
            end
        end
        $display("test compare done");
    endtask
    task automatic t_cap;
        logic [15:0] snap;
        for (int m = 4; m < 8; m++) begin
            xfer(1, `DCC_ADDR_MODE, 32'h0);
            xfer(1, `DCC_ADDR_STATUS, 32'h3);
            run <= 0;
            @(posedge pclk);
            snap = timer;
            xfer(1, `DCC_ADDR_MODE, 32'(m));
            pulses((m == 7) ? 15 : (m == 6) ? 3 : 0);
            check(irq, 1'b0);
            cap <= 1;
            repeat (3) @(posedge pclk);
            check(irq, m != 4);
            pulses(1);
            wait_irq(10);
            xfer(0, `DCC_ADDR_VAL1, 32'h0);
            check(rd, {16'h0, snap});
            run <= 1;
        end
        xfer(1, `DCC_ADDR_MODE, 32'h0);
        xfer(1, `DCC_ADDR_STATUS, 32'h3);
        xfer(1, `DCC_ADDR_MODE, 32'h6);
        pulses(2);
        xfer(1, `DCC_ADDR_MODE, 32'h0);
        xfer(1, `DCC_ADDR_MODE, 32'h6);
        pulses(3);
        check(irq, 1'b0);
        pulses(1);
        wait_irq(10);
        $display("test capture done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs;
        t_cmp;
        t_cap;
        close_out;
    end
endmodule

//--- hdl/dcc_chan.sv
`timescale 1ns/1ps
`include "dcc_regs.svh"

module dcc_chan (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] mode,
    input wire logic [15:0] timer,
    input wire logic cap_in,
    input wire logic val_we,
    input wire logic [15:0] val_wdata,
    output dcc_pkg::dcc_chan_st_t st
);
    import dcc_pkg::*;

    dcc_chan_st_t st_ff;
    dcc_chan_st_t nxt_st;

    assign st = st_ff;

    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m[3:2] == 2'b01);
    endfunction

    always_comb begin
        logic rise;
        logic fall;
        logic hit;
        logic match;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        match = 1'b0;
        nxt_st = st_ff;
        nxt_st.event_p = 1'b0;
        nxt_st.trig_p = 1'b0;
        nxt_st.in_prev = cap_in;
        rise = cap_in && !st_ff.in_prev;
        fall = !cap_in && st_ff.in_prev;
        match = (st_ff.val == timer);
        if (val_we) begin
            nxt_st.val = val_wdata;
        end
        if (mode[3:2] == 2'b00) begin
            // Off: prescaler and pin latch back to defaults, value kept
            nxt_st.pre_cnt = 4'h0;
            nxt_st.pin = 1'b0;
        end else if (is_capture(mode)) begin
            unique case (mode)
                DCC_M_CAP_FALL: hit = fall;
                DCC_M_CAP_RISE: hit = rise;
                DCC_M_CAP_R4: begin
                    if (rise) begin
                        hit = (st_ff.pre_cnt[1:0] == `DCC_PRE4_LAST);
                        nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
                    end
                end
                default: begin
                    if (rise) begin
                        hit = (st_ff.pre_cnt == `DCC_PRE16_LAST);
                        nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
                    end
                end
            endcase
            if (hit) begin
                nxt_st.val = timer;
                nxt_st.event_p = 1'b1;
            end
        end else begin
            nxt_st.pre_cnt = 4'h0;
            // Timer is only read here, never cleared
            if (match && !val_we) begin
                unique case (mode)
                    DCC_M_CMP_SET: begin
                        nxt_st.pin = 1'b1;
                        nxt_st.event_p = 1'b1;
                    end
                    DCC_M_CMP_CLR: begin
                        // Latch is kept inverted in clear mode
                        nxt_st.pin = 1'b1;
                        nxt_st.event_p = 1'b1;
                    end
                    DCC_M_CMP_TOG: begin
                        nxt_st.pin = !st_ff.pin;
                        nxt_st.event_p = 1'b1;
                    end
                    DCC_M_RSVD: ;
                    DCC_M_TRIG: begin
                        nxt_st.event_p = 1'b1;
                        nxt_st.trig_p = 1'b1;
                    end
                    default: nxt_st.event_p = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

//--- hdl/dcc_pkg.sv
package dcc_pkg;

    typedef enum logic [3:0] {
        DCC_M_CAP_FALL = 4'h4,
        DCC_M_CAP_RISE = 4'h5,
        DCC_M_CAP_R4 = 4'h6,
        DCC_M_CAP_R16 = 4'h7,
        DCC_M_CMP_SET = 4'h8,
        DCC_M_CMP_CLR = 4'h9,
        DCC_M_CMP_TOG = 4'ha,
        DCC_M_RSVD = 4'hb,
        DCC_M_SWI_0 = 4'hc,
        DCC_M_SWI_1 = 4'hd,
        DCC_M_SWI_2 = 4'he,
        DCC_M_TRIG = 4'hf
    } dcc_mode_t;

    typedef struct packed {
        logic [3:0] pre_cnt;
        logic in_prev;
        logic pin;
        logic [15:0] val;
        logic event_p;
        logic trig_p;
    } dcc_chan_st_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dcc_apb_rsp_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [1:0] status;
        logic [1:0] mask;
        dcc_apb_rsp_t rsp;
        logic irq;
        logic adc_trig;
        logic [1:0] pin;
    } dcc_top_st_t;

endpackage

//--- hdl/dcc_regs.svh
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

// Register byte addresses
`define DCC_ADDR_MODE 12'h000
`define DCC_ADDR_STATUS 12'h004
`define DCC_ADDR_MASK 12'h008
`define DCC_ADDR_VAL1 12'h00c
`define DCC_ADDR_VAL2 12'h010
`define DCC_ADDR_TIMER 12'h014
`define DCC_ADDR_PINS 12'h018

// Mode register fields
`define DCC_CH1_LSB 0
`define DCC_CH2_LSB 4

// Status / mask bit positions
`define DCC_ST_FLAG1 0
`define DCC_ST_FLAG2 1

// Reset values
`define DCC_MODE_RST 8'h00
`define DCC_MASK_RST 2'h0

// Prescaler counts
`define DCC_PRE4_LAST 4'h3
`define DCC_PRE16_LAST 4'hf

`endif

//--- hdl/dcc_top.sv
// Contract
// - Mode register: channel two in bits 7-4, one in 3-0, reset zero.
// - Channel one mode field uses the same encoding as channel two.
// - Mode 00xx switches the channel off and resets its state; the code resets only the prescaler and pin latch and keeps the value register.
// - 0100-0111 capture on fall, rise, every 4th, every 16th rise.
// - Mode 1000 drives output high on match and sets flag.
// - 1001 drives output low, 1010 toggles it, each sets flag.
// - Modes 1100-1110 only set the flag; all 11xx modes leave the compare pin as I/O.
// - Mode 1111 sets flag and triggers conversion if converter enabled.
// - Matches and triggers never clear the timer.
// - Capture copies timer on event, sets flag, overwrites old value.
// - Prescaler cleared when off, not capturing, or on reset.
// - Clearing mode returns output latch to default level.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dcc_regs.svh"

module dcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] sixteen_bit_timer,
    input wire logic capture_input_pin,
    input wire logic adc_enabled,
    output logic channel_one_compare_pin,
    output logic channel_two_compare_pin,
    output logic channel_one_compare_oe,
    output logic channel_two_compare_oe,
    output logic adc_start,
    output logic irq
);
    import dcc_pkg::*;

    dcc_top_st_t st_ff;
    dcc_top_st_t nxt_st;
    dcc_chan_st_t ch1;
    dcc_chan_st_t ch2;
    logic acc;
    logic wr;
    logic [3:0] m1;
    logic [3:0] m2;
    logic oe1_ff;
    logic oe2_ff;

    // =========================================
    // APB decode
    assign acc = psel && penable && st_ff.rsp.pready;
    assign wr = acc && pwrite;
    assign m1 = st_ff.mode[`DCC_CH1_LSB +: 4];
    assign m2 = st_ff.mode[`DCC_CH2_LSB +: 4];

    function automatic logic drives_pin(input logic [3:0] m);
        drives_pin = (m == DCC_M_CMP_SET) || (m == DCC_M_CMP_CLR) ||
                     (m == DCC_M_CMP_TOG);
    endfunction

    function automatic logic pin_level(input logic [3:0] m,
                                       input logic latch);
        // Clear-on-match output idles high (latch low); off forces default at once
        if (m[3:2] == 2'b00) begin
            pin_level = 1'b0;
        end else begin
            pin_level = (m == DCC_M_CMP_CLR) ? !latch : latch;
        end
    endfunction

    // =========================================
    // Channels
    dcc_chan u_ch1 (
        .pclk(pclk),
        .presetn(presetn),
        .mode(m1),
        .timer(sixteen_bit_timer),
        .cap_in(capture_input_pin),
        .val_we(wr && paddr == `DCC_ADDR_VAL1),
        .val_wdata(pwdata[15:0]),
        .st(ch1)
    );

    dcc_chan u_ch2 (
        .pclk(pclk),
        .presetn(presetn),
        .mode(m2),
        .timer(sixteen_bit_timer),
        .cap_in(capture_input_pin),
        .val_we(wr && paddr == `DCC_ADDR_VAL2),
        .val_wdata(pwdata[15:0]),
        .st(ch2)
    );

    // =========================================
    // Registers, flags, outputs
    always_comb begin
        logic [1:0] ev;
        ev = {ch2.event_p, ch1.event_p};
        nxt_st = st_ff;
        nxt_st.rsp.pready = 1'b1;
        nxt_st.rsp.pslverr = 1'b0;
        if (psel && !penable) begin
            nxt_st.rsp.prdata = 32'h0;
            unique case (paddr)
                `DCC_ADDR_MODE: nxt_st.rsp.prdata[7:0] = st_ff.mode;
                `DCC_ADDR_STATUS: nxt_st.rsp.prdata[1:0] = st_ff.status;
                `DCC_ADDR_MASK: nxt_st.rsp.prdata[1:0] = st_ff.mask;
                `DCC_ADDR_VAL1: nxt_st.rsp.prdata[15:0] = ch1.val;
                `DCC_ADDR_VAL2: nxt_st.rsp.prdata[15:0] = ch2.val;
                `DCC_ADDR_TIMER:
                    nxt_st.rsp.prdata[15:0] = sixteen_bit_timer;
                `DCC_ADDR_PINS: nxt_st.rsp.prdata[1:0] = st_ff.pin;
                default: nxt_st.rsp.pslverr = 1'b1;
            endcase
        end else if (!acc) begin
            nxt_st.rsp.pslverr = st_ff.rsp.pslverr && psel;
        end
        if (wr && paddr == `DCC_ADDR_MODE) begin
            nxt_st.mode = pwdata[7:0];
        end
        if (wr && paddr == `DCC_ADDR_MASK) begin
            nxt_st.mask = pwdata[1:0];
        end
        if (wr && paddr == `DCC_ADDR_STATUS) begin
            nxt_st.status = st_ff.status & ~pwdata[1:0];
        end
        // Set wins over a same-cycle clear
        nxt_st.status = nxt_st.status | ev;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
        nxt_st.adc_trig = (ch1.trig_p || ch2.trig_p) && adc_enabled;
        nxt_st.pin[0] = pin_level(m1, ch1.pin);
        nxt_st.pin[1] = pin_level(m2, ch2.pin);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.mode <= `DCC_MODE_RST;
            st_ff.mask <= `DCC_MASK_RST;
            st_ff.rsp.pready <= 1'b1;
            oe1_ff <= 1'b0;
            oe2_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            oe1_ff <= drives_pin(m1);
            oe2_ff <= drives_pin(m2);
        end
    end

    assign prdata = st_ff.rsp.prdata;
    assign pready = st_ff.rsp.pready;
    assign pslverr = st_ff.rsp.pslverr;
    assign irq = st_ff.irq;
    assign adc_start = st_ff.adc_trig;
    assign channel_one_compare_pin = st_ff.pin[0];
    assign channel_two_compare_pin = st_ff.pin[1];
    assign channel_one_compare_oe = oe1_ff;
    assign channel_two_compare_oe = oe2_ff;

endmodule
